// >>> inc/led_sink_defs.svh
// constants of the serial on/off control block
`ifndef LED_SINK_DEFS_SVH
`define LED_SINK_DEFS_SVH

`define LSK_CHANNELS        16
`define LSK_FIFO_DEPTH      32
`define LSK_FIFO_WIDTH      1
`define LSK_STAT_THERM_BIT  15
`define LSK_LATCH_RST       16'h0000
`define LSK_SHIFT_RST       16'h0000
`define LSK_STATUS_RST      16'h0000
`define LSK_CLK_PERIOD_NS   10
`define LSK_LAT_SCLK_NS     100
`define LSK_LAT_SCLK_CYC    ((`LSK_LAT_SCLK_NS + `LSK_CLK_PERIOD_NS - 1) / `LSK_CLK_PERIOD_NS)

`endif

// >>> inc/led_sink_pkg.sv
// types of the serial on/off control block
package led_sink_pkg;
    typedef logic [15:0] chan_word_t;
endpackage

// >>> logic/led_sink_ctrl.sv
// serial on/off control of a sixteen channel current sink driver, with its bit fifo
`include "led_sink_defs.svh"

// ****************************************************************
// bit fifo
// ****************************************************************
module led_sink_fifo #(
    parameter int WIDTH = `LSK_FIFO_WIDTH,
    parameter int DEPTH = `LSK_FIFO_DEPTH
) (
    // clock and reset
    input  wire logic             clk_i,
    input  wire logic             reset_n_i,
    // fill side
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    input  wire logic [WIDTH-1:0] in_data_i,
    // drain side
    output logic                  out_valid_o,
    input  wire logic             out_ready_i,
    output logic      [WIDTH-1:0] out_data_o
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    // head is read combinationally, so pop and data meet in one cycle

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr_reg;
    logic [AW-1:0]    wr_ptr_next;
    logic [AW-1:0]    rd_ptr_reg;
    logic [AW-1:0]    rd_ptr_next;
    logic [AW:0]      count_reg;
    logic [AW:0]      count_next;
    wire              push;
    wire              pop;

    assign in_ready_o  = (count_reg != (AW+1)'(DEPTH));
    assign out_valid_o = (count_reg != '0);
    assign out_data_o  = mem[rd_ptr_reg];
    assign push        = in_valid_i & in_ready_o;
    assign pop         = out_valid_o & out_ready_i;
    assign wr_ptr_next = (wr_ptr_reg == AW'(DEPTH - 1)) ? '0 : wr_ptr_reg + 1'b1;
    assign rd_ptr_next = (rd_ptr_reg == AW'(DEPTH - 1)) ? '0 : rd_ptr_reg + 1'b1;
    assign count_next  = count_reg + (AW+1)'(push) - (AW+1)'(pop);

    always_ff @(posedge clk_i) begin
        if (push) begin
            mem[wr_ptr_reg] <= in_data_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg  <= '0;
        end else begin
            if (push) begin
                wr_ptr_reg <= wr_ptr_next;
            end
            if (pop) begin
                rd_ptr_reg <= rd_ptr_next;
            end
            count_reg <= count_next;
        end
    end
endmodule

// ****************************************************************
// control top
// ****************************************************************
// Contract
// - each rising shift clock edge stores the serial input level into bit 0, high as one.
// - each rising shift clock edge moves every shift register bit one place toward bit 15.
// - a rising strobe edge copies the whole shift register into the on/off latch.
// - the same strobe edge reloads the shift register with open-led and thermal status.
// - while blanking is high all sixteen sinks are off regardless of the latch.
// - while blanking is low each sink follows its on/off latch bit.
// - a rising blanking edge captures the status, shown at the capture output while blanking is low.
// - the serial output shows bit 15 of the shift register and changes on shift clock rises.
// - a latch bit of one turns its sink on, zero keeps it off, when not blanking.
module led_sink_ctrl (
    // clock and reset
    input  wire logic                    CLOCK_I,
    input  wire logic                    RESET_N_I,
    // serial link pins
    input  wire logic                    SHIFT_CLOCK_I,
    input  wire logic                    SERIAL_IN_I,
    input  wire logic                    TRANSFER_STROBE_I,
    input  wire logic                    BLANK_I,
    output logic                         SERIAL_OUT_O,
    // detector inputs
    input  wire led_sink_pkg::chan_word_t OPEN_LED_FLAG_I,
    input  wire logic                    THERMAL_WARNING_FLAG_I,
    // sink and status outputs
    output led_sink_pkg::chan_word_t     CURRENT_SINKS_O,
    output led_sink_pkg::chan_word_t     STATUS_CAPTURE_LATCH_O,
    output logic                         BUFFER_FULL_O
);
    import led_sink_pkg::*;

    // ****************************************************************
    // pin synchronisers
    // ****************************************************************
    // pins are async to CLOCK_I, so two flops before any logic
    // shift clock and strobe must sit low in reset, else a false edge follows
    logic       sclk_s1_reg;
    logic       sclk_s2_reg;
    logic       sclk_d_reg;
    logic       sin_s1_reg;
    logic       sin_s2_reg;
    logic       lat_s1_reg;
    logic       lat_s2_reg;
    logic       lat_d_reg;
    logic       blank_s1_reg;
    logic       blank_s2_reg;
    logic       blank_d_reg;
    chan_word_t open_s1_reg;
    chan_word_t open_s2_reg;
    logic       therm_s1_reg;
    logic       therm_s2_reg;

    always_ff @(posedge CLOCK_I) begin
        if (!RESET_N_I) begin
            sclk_s1_reg  <= 1'b0;
            sclk_s2_reg  <= 1'b0;
            sclk_d_reg   <= 1'b0;
            sin_s1_reg   <= 1'b0;
            sin_s2_reg   <= 1'b0;
            lat_s1_reg   <= 1'b0;
            lat_s2_reg   <= 1'b0;
            lat_d_reg    <= 1'b0;
            blank_s1_reg <= 1'b1;
            blank_s2_reg <= 1'b1;
            blank_d_reg  <= 1'b1;
            open_s1_reg  <= 16'h0000;
            open_s2_reg  <= 16'h0000;
            therm_s1_reg <= 1'b0;
            therm_s2_reg <= 1'b0;
        end else begin
            sclk_s1_reg  <= SHIFT_CLOCK_I;
            sclk_s2_reg  <= sclk_s1_reg;
            sclk_d_reg   <= sclk_s2_reg;
            sin_s1_reg   <= SERIAL_IN_I;
            sin_s2_reg   <= sin_s1_reg;
            lat_s1_reg   <= TRANSFER_STROBE_I;
            lat_s2_reg   <= lat_s1_reg;
            lat_d_reg    <= lat_s2_reg;
            blank_s1_reg <= BLANK_I;
            blank_s2_reg <= blank_s1_reg;
            blank_d_reg  <= blank_s2_reg;
            open_s1_reg  <= OPEN_LED_FLAG_I;
            open_s2_reg  <= open_s1_reg;
            therm_s1_reg <= THERMAL_WARNING_FLAG_I;
            therm_s2_reg <= therm_s1_reg;
        end
    end

    // edges compare the second flop with its delayed copy
    wire sclk_rise  = sclk_s2_reg & ~sclk_d_reg;
    wire lat_rise   = lat_s2_reg & ~lat_d_reg;
    wire blank_rise = blank_s2_reg & ~blank_d_reg;

    // ****************************************************************
    // status word
    // ****************************************************************
    // only sixteen places, so the thermal flag takes bit 15
    // limitation: the open-led state of channel 15 is never reported
    chan_word_t status_word;
    genvar n;
    generate
        for (n = 0; n < `LSK_CHANNELS; n++) begin : g_stat
            if (n == `LSK_STAT_THERM_BIT) begin : g_therm
                assign status_word[n] = therm_s2_reg;
            end else begin : g_open
                assign status_word[n] = open_s2_reg[n];
            end
        end
    endgenerate

    // ****************************************************************
    // bit fifo between link and shift register
    // ****************************************************************
    logic fifo_ready;
    logic fifo_valid;
    logic fifo_bit;
    logic lat_pend_reg;
    wire  lat_apply = lat_pend_reg & ~fifo_valid;
    // shifting stalls while a strobe is applied so the order holds
    wire  shift_pop = fifo_valid & ~lat_apply;

    led_sink_fifo #(
        .WIDTH (`LSK_FIFO_WIDTH),
        .DEPTH (`LSK_FIFO_DEPTH)
    ) u_fifo (
        .clk_i       (CLOCK_I),
        .reset_n_i   (RESET_N_I),
        .in_valid_i  (sclk_rise),
        .in_ready_o  (fifo_ready),
        .in_data_i   (sin_s2_reg),
        .out_valid_o (fifo_valid),
        .out_ready_i (shift_pop),
        .out_data_o  (fifo_bit)
    );

    // ****************************************************************
    // shift register, latches and outputs
    // ****************************************************************
    chan_word_t shift_reg;
    chan_word_t shift_next;
    chan_word_t latch_reg;
    chan_word_t status_cap_reg;
    chan_word_t sinks_next;
    chan_word_t status_out_next;

    // queued shifts win: the strobe waits until they have drained
    assign shift_next = lat_apply ? status_word :
                        shift_pop ? {shift_reg[14:0], fifo_bit} : shift_reg;
    // blank forces all off, else one means on
    assign sinks_next      = blank_s2_reg ? 16'h0000 : latch_reg;
    assign status_out_next = blank_s2_reg ? 16'h0000 : status_cap_reg;

    always_ff @(posedge CLOCK_I) begin
        if (!RESET_N_I) begin
            lat_pend_reg <= 1'b0;
        end else begin
            // a new strobe edge wins over the clear
            lat_pend_reg <= lat_rise | (lat_pend_reg & ~lat_apply);
        end
    end

    always_ff @(posedge CLOCK_I) begin
        if (!RESET_N_I) begin
            shift_reg <= `LSK_SHIFT_RST;
        end else begin
            shift_reg <= shift_next;
        end
    end

    always_ff @(posedge CLOCK_I) begin
        if (!RESET_N_I) begin
            latch_reg <= `LSK_LATCH_RST;
        end else if (lat_apply) begin
            latch_reg <= shift_reg;
        end
    end

    always_ff @(posedge CLOCK_I) begin
        if (!RESET_N_I) begin
            status_cap_reg <= `LSK_STATUS_RST;
        end else if (blank_rise) begin
            status_cap_reg <= status_word;
        end
    end

    // ****************************************************************
    // output registers
    // ****************************************************************
    // pops run every cycle the fifo holds a bit, so full is a guard only
    wire full_next = ~fifo_ready;

    always_ff @(posedge CLOCK_I) begin
        if (!RESET_N_I) begin
            CURRENT_SINKS_O <= `LSK_LATCH_RST;
        end else begin
            CURRENT_SINKS_O <= sinks_next;
        end
    end

    always_ff @(posedge CLOCK_I) begin
        if (!RESET_N_I) begin
            STATUS_CAPTURE_LATCH_O <= `LSK_STATUS_RST;
        end else begin
            STATUS_CAPTURE_LATCH_O <= status_out_next;
        end
    end

    always_ff @(posedge CLOCK_I) begin
        if (!RESET_N_I) begin
            SERIAL_OUT_O <= 1'b0;
        end else begin
            SERIAL_OUT_O <= shift_next[15];
        end
    end

    always_ff @(posedge CLOCK_I) begin
        if (!RESET_N_I) begin
            BUFFER_FULL_O <= 1'b0;
        end else begin
            // shift clock rises are dropped while high
            BUFFER_FULL_O <= full_next;
        end
    end
endmodule

// >>> verif/led_sink_ctrl_sva.sv
// port assertions of the serial on/off control block
module led_sink_ctrl_sva (
    // watched ports
    input  wire logic                     CLOCK_I,
    input  wire logic                     RESET_N_I,
    input  wire logic                     SHIFT_CLOCK_I,
    input  wire logic                     TRANSFER_STROBE_I,
    input  wire logic                     BLANK_I,
    input  wire logic                     SERIAL_OUT_O,
    input  wire led_sink_pkg::chan_word_t CURRENT_SINKS_O,
    input  wire led_sink_pkg::chan_word_t STATUS_CAPTURE_LATCH_O,
    input  wire logic                     BUFFER_FULL_O
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge CLOCK_I); endclocking
    default disable iff (!RESET_N_I);
    // cycles since the last strobe or blanking activity
    logic [3:0] quiet_cnt;
    logic       blank_q;
    wire logic  stir = TRANSFER_STROBE_I || (BLANK_I != blank_q);
    always_ff @(posedge CLOCK_I) begin
        blank_q   <= BLANK_I;
        quiet_cnt <= (!RESET_N_I || stir) ? 4'h0 : quiet_cnt + {3'h0, quiet_cnt != 4'hf};
    end
    sequence blanked;    BLANK_I[*4]; endsequence
    sequence unblanked;  (!BLANK_I)[*5]; endsequence
    sequence link_quiet; (!SHIFT_CLOCK_I && !TRANSFER_STROBE_I)[*8]; endsequence
    a_reset_clear: assert property ($rose(RESET_N_I) |-> CURRENT_SINKS_O == 16'h0000
        && STATUS_CAPTURE_LATCH_O == 16'h0000 && !SERIAL_OUT_O && !BUFFER_FULL_O)
        else $error("outputs not cleared by reset");
    a_blank_off: assert property (blanked |-> CURRENT_SINKS_O == 16'h0000
        && STATUS_CAPTURE_LATCH_O == 16'h0000) else $error("sinks on while blanked");
    a_sinks_need_unblank: assert property (CURRENT_SINKS_O != 16'h0000 |->
        !$past(BLANK_I, 3)) else $error("sinks on too soon after blanking");
    a_status_needs_unblank: assert property (STATUS_CAPTURE_LATCH_O != 16'h0000 |->
        !$past(BLANK_I, 3)) else $error("status shown while blanked");
    a_capture_hold: assert property (unblanked |-> $stable(STATUS_CAPTURE_LATCH_O))
        else $error("status capture moved while unblanked");
    a_sinks_cause: assert property ($changed(CURRENT_SINKS_O) |-> quiet_cnt < 4'h8)
        else $error("sinks changed without strobe or blanking");
    a_serial_out_quiet: assert property (link_quiet |-> $stable(SERIAL_OUT_O))
        else $error("serial output moved without shift or strobe");
    a_full_idle: assert property ((!SHIFT_CLOCK_I)[*8] |-> !BUFFER_FULL_O)
        else $error("buffer full with idle link");
endmodule

bind led_sink_ctrl led_sink_ctrl_sva chk_u (.CLOCK_I(CLOCK_I), .RESET_N_I(RESET_N_I),
    .SHIFT_CLOCK_I(SHIFT_CLOCK_I), .TRANSFER_STROBE_I(TRANSFER_STROBE_I), .BLANK_I(BLANK_I),
    .SERIAL_OUT_O(SERIAL_OUT_O), .CURRENT_SINKS_O(CURRENT_SINKS_O),
    .STATUS_CAPTURE_LATCH_O(STATUS_CAPTURE_LATCH_O), .BUFFER_FULL_O(BUFFER_FULL_O));

// >>> verif/led_sink_ctrl_tb.sv
// self-checking bench of the serial on/off control block
module led_sink_ctrl_tb;
    timeunit 1ns;
    timeprecision 100ps;
    import led_sink_pkg::*;
    logic       clk = 0, rst_n = 0, blank = 1, therm = 0, send = 0;
    chan_word_t open_f = '0, word = '0, sinks, stat, shifted, prev_st, st, w;
    wire logic  sclk, serial_in, lat, serial_out, busy, full;
    int         miscompares = 0, samples_checked = 0, seed = 32'h902a7086;
    always #5 clk = ~clk;
    led_sink_ctrl dut_u (.CLOCK_I(clk), .RESET_N_I(rst_n), .SHIFT_CLOCK_I(sclk),
        .SERIAL_IN_I(serial_in), .TRANSFER_STROBE_I(lat), .BLANK_I(blank), .SERIAL_OUT_O(serial_out),
        .OPEN_LED_FLAG_I(open_f), .THERMAL_WARNING_FLAG_I(therm), .CURRENT_SINKS_O(sinks),
        .STATUS_CAPTURE_LATCH_O(stat), .BUFFER_FULL_O(full));
    led_sink_host host_u (.send_i(send), .word_i(word), .busy_o(busy), .sclk_o(sclk),
        .sin_o(serial_in), .lat_o(lat), .serial_out_i(serial_out), .shifted_o(shifted));
    task automatic chk_word(string what, chan_word_t exp, chan_word_t got);
        samples_checked++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic chk_bit(string what, logic exp, logic got);
        chk_word(what, {15'h0000, exp}, {15'h0000, got});
    endtask
    task automatic print_verdict();
        if (miscompares == 0 && samples_checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic tick(int n);
        repeat (n) @(posedge clk);
    endtask
    // status word: thermal flag on top, open-led flags below
    function automatic chan_word_t status_of(chan_word_t o, logic t);
        return {t, o[14:0]};
    endfunction
    task automatic frame(chan_word_t v);
        int k;
        word <= v;
        send <= 1'b1;
        tick(1);
        send <= 1'b0;
        for (k = 0; k < 5000 && busy; k++) tick(1);
        if (busy) begin
            miscompares++;
            print_verdict();
        end
        tick(10);
    endtask
    initial begin
        tick(20);
        rst_n <= 1'b1;
        prev_st = '0;
        for (int i = 0; i < 10; i++) begin
            w = (i == 0) ? 16'h8001 : (i == 1) ? 16'hffff : (i == 2) ? 16'h0000 :
                16'($random(seed));
            open_f <= 16'($random(seed));
            therm  <= i[0];
            blank  <= 1'b0;
            tick(4);
            st = status_of(open_f, therm);
            frame(w);
            chk_word("sinks after strobe", w, sinks);
            chk_bit("serial out after strobe", st[15], serial_out);
            chk_word("bits shifted out", prev_st, shifted);
            chk_bit("buffer full", 1'b0, full);
            prev_st = st;
            blank <= 1'b1;
            tick(6);
            chk_word("sinks blanked", 16'h0000, sinks);
            chk_word("status while blanked", 16'h0000, stat);
            open_f <= ~open_f;
            therm  <= ~therm;
            blank  <= 1'b0;
            tick(6);
            chk_word("status capture", st, stat);
            chk_word("sinks unblanked", w, sinks);
        end
        print_verdict();
    end
endmodule

// >>> verif/led_sink_host.sv
// display controller model: shifts a frame msb first, then strobes it once
module led_sink_host (
    // request from the bench
    input  wire logic                     send_i,
    input  wire led_sink_pkg::chan_word_t word_i,
    output logic                          busy_o,
    // link pins
    output logic                          sclk_o,
    output logic                          sin_o,
    output logic                          lat_o,
    input  wire logic                     serial_out_i,
    output led_sink_pkg::chan_word_t      shifted_o
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        {busy_o, sclk_o, sin_o, lat_o, shifted_o} = '0;
        forever begin
            @(posedge send_i);
            // step off the bench clock so no pin moves on its edge
            #1;
            busy_o = 1'b1;
            for (int i = 15; i >= 0; i--) begin
                sin_o = word_i[i];
                #62.5;
                shifted_o = {shifted_o[14:0], serial_out_i};
                sclk_o = 1'b1;
                #62.5;
                sclk_o = 1'b0;
            end
            // data hold over: show the inverse rather than a stale bit
            sin_o = ~sin_o;
            #100;
            lat_o = 1'b1;
            #62.5;
            lat_o = 1'b0;
            #100;
            busy_o = 1'b0;
        end
    end
endmodule
